// ### common/ncp_pkg.sv
// Purpose: constants and carriers of the configuration packet decoder
// Assumes: payload words are little-endian, byte 0 of a packet is its id
// Notes: every packet is checked for exact length before it acts
package ncp_pkg;
  localparam logic [7:0] ID_CAL_CMD = 8'hBE;
  localparam logic [7:0] ID_CAL_STAT = 8'hBF;
  localparam logic [7:0] ID_ODO = 8'hC0;
  localparam logic [7:0] ID_ALIGN = 8'hC1;
  localparam logic [7:0] ID_OFFS = 8'hC2;
  localparam logic [5:0] LEN_CAL_CMD = 6'h01;
  localparam logic [5:0] LEN_ODO = 6'h08;
  localparam logic [5:0] LEN_ALIGN = 6'h05;
  localparam logic [5:0] LEN_OLD_ALIGN = 6'h01;
  localparam logic [5:0] LEN_OFFS = 6'h31;
  localparam logic [5:0] MAX_LEN = 6'h31;
  localparam int PERSIST_POS = 0;
  localparam int ODO_AUTO_POS = 1;
  localparam int ODO_LEN_POS = 4;
  localparam int KEY_POS = 1;
  localparam int OFF_FIRST = 1;
  localparam int OFF_LAST = 45;
  localparam int N_OFFS = 12;
  localparam logic [31:0] ALIGN_KEY = 32'h9A4E8055;
  localparam logic [7:0] ACT_CANCEL = 8'h00;
  localparam logic [7:0] ACT_2D = 8'h02;
  localparam logic [7:0] ACT_3D = 8'h03;
  localparam logic [7:0] ACT_DEFAULT = 8'h04;
  localparam logic [7:0] ST_NONE = 8'h00;
  localparam logic [7:0] ST_DONE2D = 8'h01;
  localparam logic [7:0] ST_DONE3D = 8'h02;
  localparam logic [7:0] ST_CUSTOM = 8'h03;
  localparam logic [7:0] ST_RUN2D = 8'h05;
  localparam logic [7:0] ST_RUN3D = 8'h06;
  localparam logic [7:0] ST_ERR_ROLL = 8'h07;
  localparam logic [7:0] ST_ERR_PITCH = 8'h08;
  localparam logic [7:0] ST_ERR_RANGE = 8'h09;
  localparam logic [7:0] ST_ERR_TIMEOUT = 8'h0A;
  localparam logic [7:0] ST_ERR_SYS = 8'h0B;
  localparam logic [7:0] ST_ERR_INTF = 8'h0C;
  localparam logic [7:0] A_IRQ_STAT = 8'h00;
  localparam logic [7:0] A_IRQ_MASK = 8'h04;
  localparam logic [7:0] A_CAL = 8'h08;
  localparam logic [7:0] A_ODO_CTL = 8'h0C;
  localparam logic [7:0] A_ODO_LEN = 8'h10;
  localparam int N_IRQ = 4;
  localparam logic [3:0] RST_MASK = 4'h0;
  typedef enum logic {PS_IDLE, PS_BODY} ncp_ps_t;
  typedef struct packed {
    logic sop;
    logic valid;
    logic last;
    logic [7:0] data;
  } ncp_pkt_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ncp_apb_req_t;
  typedef struct packed {
    logic cancel;
    logic start2d;
    logic start3d;
    logic defaults;
  } ncp_cal_cmd_t;
  typedef struct packed {
    logic done;
    logic fail;
    logic custom;
    logic [7:0] fail_code;
    logic [7:0] progress;
    logic [7:0] error;
  } ncp_cal_evt_t;
  typedef struct packed {
    logic [7:0] id;
    logic [7:0] code;
    logic [7:0] progress;
    logic [7:0] error;
  } ncp_cal_rpt_t;
  typedef struct packed {
    logic valid;
    logic [7:0] id;
  } ncp_save_t;
  typedef struct packed {
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] z;
  } ncp_xyz_t;
endpackage

// ### design/ncp_decoder.sv
// Purpose: decode configuration packets, hold settings, report status
// Assumes: apb zero wait; packet bytes arrive one per valid cycle
// Notes: ids outside this group pass silently without an event
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module ncp_decoder (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // apb slave
  input wire ncp_pkg::ncp_apb_req_t apb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // packet stream
  input wire ncp_pkg::ncp_pkt_t pkt_in,
  // calibration engine
  input wire ncp_pkg::ncp_cal_evt_t cal_evt_in,
  output ncp_pkg::ncp_cal_cmd_t cal_cmd_out,
  output ncp_pkg::ncp_cal_rpt_t cal_rpt_out,
  // odometer
  output logic odo_auto_out,
  output logic [31:0] odo_len_out,
  // alignment and offsets
  output logic align_out,
  output ncp_pkg::ncp_xyz_t prim_off_out,
  output ncp_pkg::ncp_xyz_t [2:0] heave_off_out,
  // persistence and interrupt
  output ncp_pkg::ncp_save_t save_out,
  output logic irq_out
);

  ncp_pkg::ncp_ps_t ps_q;
  logic [7:0] id_q;
  logic [5:0] len_q;
  logic ovf_q;
  logic done_q;
  logic [48:0][7:0] buf_q;
  logic [11:0][31:0] off_q;
  logic ok_len, key_ok, act_ok, known, accept, reject, persist;
  logic cmd_go, running;
  logic [7:0] cal_code_q, cal_code_d, prog_q, err_q;
  ncp_pkg::ncp_cal_cmd_t cmd_q;
  ncp_pkg::ncp_save_t save_q;
  logic odo_auto_q, align_q;
  logic [31:0] odo_len_q;
  logic [3:0] stat_q, mask_q, ev;
  logic [31:0] prdata_q;
  logic slverr_q;
  logic setup, acc;

  // parser: byte with sop is the id, payload bytes follow
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ps_q <= ncp_pkg::PS_IDLE;
      id_q <= 8'h00;
      len_q <= 6'h00;
      ovf_q <= 1'b0;
    end
    else if (pkt_in.valid)
    begin
      if (pkt_in.sop)
      begin
        id_q <= pkt_in.data;
        len_q <= 6'h00;
        ovf_q <= 1'b0;
        ps_q <= pkt_in.last ? ncp_pkg::PS_IDLE : ncp_pkg::PS_BODY;
      end
      else if (ps_q == ncp_pkg::PS_BODY)
      begin
        // overlong packets saturate rather than wrap the buffer
        if (len_q == ncp_pkg::MAX_LEN)
          ovf_q <= 1'b1;
        else
          len_q <= len_q + 6'h01;
        if (pkt_in.last)
          ps_q <= ncp_pkg::PS_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      done_q <= 1'b0;
    else
      done_q <= pkt_in.valid && pkt_in.last &&
                (pkt_in.sop || ps_q == ncp_pkg::PS_BODY);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      buf_q <= '0;
    else if (pkt_in.valid && !pkt_in.sop &&
             ps_q == ncp_pkg::PS_BODY && len_q != ncp_pkg::MAX_LEN)
      buf_q[len_q] <= pkt_in.data;
  end

  // decode one cycle after the last byte
  always_comb
  begin
    case (id_q)
      ncp_pkg::ID_CAL_CMD: ok_len = len_q == ncp_pkg::LEN_CAL_CMD;
      ncp_pkg::ID_ODO: ok_len = len_q == ncp_pkg::LEN_ODO;
      ncp_pkg::ID_ALIGN: ok_len = len_q == ncp_pkg::LEN_ALIGN;
      ncp_pkg::ID_OFFS: ok_len = len_q == ncp_pkg::LEN_OFFS;
      default: ok_len = 1'b0;
    endcase
  end

  assign known = id_q inside {ncp_pkg::ID_CAL_CMD, ncp_pkg::ID_ODO,
                              ncp_pkg::ID_ALIGN, ncp_pkg::ID_OFFS};
  assign key_ok = buf_q[ncp_pkg::KEY_POS +: 4] == ncp_pkg::ALIGN_KEY;
  assign act_ok = buf_q[0] inside {ncp_pkg::ACT_CANCEL, ncp_pkg::ACT_2D,
                                   ncp_pkg::ACT_3D, ncp_pkg::ACT_DEFAULT};
  assign accept = done_q && ok_len && !ovf_q &&
                  (id_q != ncp_pkg::ID_ALIGN || key_ok) &&
                  (id_q != ncp_pkg::ID_CAL_CMD || act_ok);
  assign reject = done_q && known && !accept;
  assign persist = buf_q[ncp_pkg::PERSIST_POS] != 8'h00;
  assign cmd_go = accept && id_q == ncp_pkg::ID_CAL_CMD;
  assign running = cal_code_q == ncp_pkg::ST_RUN2D ||
                   cal_code_q == ncp_pkg::ST_RUN3D;

  // calibration status; a host command outranks an engine event
  always_comb
  begin
    cal_code_d = cal_code_q;
    if (cmd_go)
    begin
      case (buf_q[0])
        ncp_pkg::ACT_2D: cal_code_d = ncp_pkg::ST_RUN2D;
        ncp_pkg::ACT_3D: cal_code_d = ncp_pkg::ST_RUN3D;
        ncp_pkg::ACT_DEFAULT: cal_code_d = ncp_pkg::ST_NONE;
        default:
          if (running)
            cal_code_d = ncp_pkg::ST_NONE;
      endcase
    end
    else if (cal_evt_in.custom)
      cal_code_d = ncp_pkg::ST_CUSTOM;
    else if (running && cal_evt_in.done)
      cal_code_d = (cal_code_q == ncp_pkg::ST_RUN2D) ?
                   ncp_pkg::ST_DONE2D : ncp_pkg::ST_DONE3D;
    else if (running && cal_evt_in.fail)
      cal_code_d = cal_evt_in.fail_code;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      cal_code_q <= ncp_pkg::ST_NONE;
      prog_q <= 8'h00;
      err_q <= 8'h00;
      cmd_q <= '0;
    end
    else
    begin
      cal_code_q <= cal_code_d;
      prog_q <= cal_evt_in.progress;
      err_q <= cal_evt_in.error;
      cmd_q.cancel <= cmd_go && buf_q[0] == ncp_pkg::ACT_CANCEL;
      cmd_q.start2d <= cmd_go && buf_q[0] == ncp_pkg::ACT_2D;
      cmd_q.start3d <= cmd_go && buf_q[0] == ncp_pkg::ACT_3D;
      cmd_q.defaults <= cmd_go && buf_q[0] == ncp_pkg::ACT_DEFAULT;
    end
  end

  // odometer, alignment and persistence
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      odo_auto_q <= 1'b0;
      odo_len_q <= 32'h00000000;
      align_q <= 1'b0;
      save_q <= '0;
    end
    else
    begin
      if (accept && id_q == ncp_pkg::ID_ODO)
      begin
        odo_auto_q <= buf_q[ncp_pkg::ODO_AUTO_POS] != 8'h00;
        odo_len_q <= buf_q[ncp_pkg::ODO_LEN_POS +: 4];
      end
      align_q <= accept && id_q == ncp_pkg::ID_ALIGN;
      // non-persistent settings simply live until the next reset
      save_q.valid <= accept && persist &&
                      id_q != ncp_pkg::ID_CAL_CMD;
      save_q.id <= id_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < ncp_pkg::N_OFFS; i++)
    begin : g_off
      always_ff @(posedge ref_clk_in)
      begin
        if (rst_in)
          off_q[i] <= 32'h00000000;
        else if (accept && id_q == ncp_pkg::ID_OFFS)
          off_q[i] <= buf_q[ncp_pkg::OFF_FIRST + 4 * i +: 4];
      end
    end
  endgenerate

  assign prim_off_out = {off_q[0], off_q[1], off_q[2]};
  assign heave_off_out = {off_q[9], off_q[10], off_q[11], off_q[6], off_q[7],
                          off_q[8], off_q[3], off_q[4], off_q[5]};
  assign cal_cmd_out = cmd_q;
  assign cal_rpt_out = {ncp_pkg::ID_CAL_STAT, cal_code_q, prog_q, err_q};
  assign odo_auto_out = odo_auto_q;
  assign odo_len_out = odo_len_q;
  assign align_out = align_q;
  assign save_out = save_q;

  // interrupts: sticky status, set wins over write-one-to-clear
  assign ev = {cal_code_d != cal_code_q, accept && id_q == ncp_pkg::ID_ALIGN,
               reject, accept};
  assign setup = apb_in.psel && !apb_in.penable;
  assign acc = apb_in.psel && apb_in.penable;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      stat_q <= 4'h0;
      mask_q <= ncp_pkg::RST_MASK;
    end
    else
    begin
      if (acc && apb_in.pwrite && apb_in.paddr == ncp_pkg::A_IRQ_STAT)
        stat_q <= (stat_q & ~apb_in.pwdata[3:0]) | ev;
      else
        stat_q <= stat_q | ev;
      if (acc && apb_in.pwrite && apb_in.paddr == ncp_pkg::A_IRQ_MASK)
        mask_q <= apb_in.pwdata[3:0];
    end
  end

  assign irq_out = |(stat_q & mask_q);

  // read data is captured in setup so that it comes from a flop
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      prdata_q <= 32'h00000000;
      slverr_q <= 1'b0;
    end
    else if (setup)
    begin
      slverr_q <= 1'b0;
      case (apb_in.paddr)
        ncp_pkg::A_IRQ_STAT: prdata_q <= {28'h0000000, stat_q};
        ncp_pkg::A_IRQ_MASK: prdata_q <= {28'h0000000, mask_q};
        ncp_pkg::A_CAL: prdata_q <= {8'h00, err_q, prog_q, cal_code_q};
        ncp_pkg::A_ODO_CTL: prdata_q <= {31'h00000000, odo_auto_q};
        ncp_pkg::A_ODO_LEN: prdata_q <= odo_len_q;
        default:
        begin
          prdata_q <= 32'h00000000;
          slverr_q <= 1'b1;
        end
      endcase
    end
  end

  assign prdata_out = prdata_q;
  assign pslverr_out = slverr_q && acc;
  assign pready_out = 1'b1;

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_cal(logic [7:0] a);
    cmd_go && buf_q[0] == a;
  endsequence
  sequence s_align_bad;
    done_q && id_q == ncp_pkg::ID_ALIGN && !key_ok;
  endsequence
  sequence s_offs;
    accept && id_q == ncp_pkg::ID_OFFS;
  endsequence

  a_len_reject: assert property (
    done_q && id_q == ncp_pkg::ID_ODO && len_q != ncp_pkg::LEN_ODO
    |=> $stable(odo_len_q) && $stable(odo_auto_q))
    else $error("odometer changed by wrong length packet");
  a_old_align: assert property (
    done_q && id_q == ncp_pkg::ID_ALIGN && len_q == ncp_pkg::LEN_OLD_ALIGN
    |=> !align_q)
    else $error("short alignment packet aligned");
  a_key_check: assert property (
    s_align_bad |=> !align_q ##1 !align_q)
    else $error("alignment with wrong key");
  a_align_fires: assert property (
    done_q && id_q == ncp_pkg::ID_ALIGN && len_q == ncp_pkg::LEN_ALIGN &&
    key_ok |=> align_q ##1 !align_q)
    else $error("alignment pulse missing");
  a_start_two: assert property (
    s_cal(ncp_pkg::ACT_2D) |=> cal_code_q == ncp_pkg::ST_RUN2D &&
    cal_cmd_out.start2d ##1 !cal_cmd_out.start2d)
    else $error("2D start not taken");
  a_start_three: assert property (
    s_cal(ncp_pkg::ACT_3D) |=> cal_code_q == ncp_pkg::ST_RUN3D)
    else $error("3D start not taken");
  a_done_two: assert property (
    cal_code_q == ncp_pkg::ST_RUN2D && cal_evt_in.done && !cmd_go &&
    !cal_evt_in.custom |=> cal_code_q == ncp_pkg::ST_DONE2D)
    else $error("2D completion code wrong");
  a_fail_code: assert property (
    running && cal_evt_in.fail && !cal_evt_in.done && !cmd_go &&
    !cal_evt_in.custom |=> cal_code_q == $past(cal_evt_in.fail_code))
    else $error("failure code not reported");
  a_reset_zero: assert property (disable iff (1'b0)
    rst_in |=> off_q == '0 && cal_code_q == ncp_pkg::ST_NONE)
    else $error("offsets not zero after reset");
  a_offs_load: assert property (
    s_offs |=> prim_off_out.x == $past(buf_q[ncp_pkg::OFF_FIRST +: 4]) &&
    heave_off_out[2].z == $past(buf_q[ncp_pkg::OFF_LAST +: 4]))
    else $error("offset words misplaced");
  a_persist: assert property (
    save_out.valid |-> $past(accept) && $past(persist))
    else $error("save without persistence byte");
  a_stat_pkt: assert property (
    ##1 cal_rpt_out.progress == $past(cal_evt_in.progress) &&
    cal_rpt_out.id == ncp_pkg::ID_CAL_STAT)
    else $error("status packet fields wrong");
endmodule

// ### tb/ncp_host.sv
// Purpose: host model that streams configuration packets byte by byte
// Assumes: one byte per clock, sop on the id byte, last on the final one
// Notes: idle data is the inverse of the last byte so stale data is seen
`timescale 1ns/10ps
module ncp_host (
  // clock
  input wire logic clk_in,
  // packet stream
  output ncp_pkg::ncp_pkt_t pkt_out
);
  initial pkt_out = '0;
  // the caller builds the bytes of each packet; sop and last are set here
  task automatic send(input logic [7:0] b[$]);
    for (int i = 0; i < b.size(); i++)
    begin
      @(posedge clk_in);
      pkt_out <= '{i == 0, 1'b1, i == b.size() - 1, b[i]};
    end
    @(posedge clk_in);
    pkt_out <= '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
  endtask
endmodule

// ### tb/tb_top.sv
// Purpose: self-checking bench of the configuration packet decoder
// Assumes: zero-wait apb, results two edges after the last byte
// Notes: event pulses are matched against a queue of notes
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    checked++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("unexpected %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  ncp_pkg::ncp_apb_req_t apb_in = '0;
  ncp_pkg::ncp_cal_evt_t cal_evt_in = '0;
  ncp_pkg::ncp_pkt_t pkt;
  ncp_pkg::ncp_cal_cmd_t cal_cmd_out;
  ncp_pkg::ncp_cal_rpt_t cal_rpt_out;
  ncp_pkg::ncp_xyz_t prim_off_out;
  ncp_pkg::ncp_xyz_t [2:0] heave_off_out;
  ncp_pkg::ncp_save_t save_out;
  logic [31:0] prdata_out, odo_len_out, rd, seed = 32'h213C45AD;
  logic pready_out, pslverr_out, odo_auto_out, align_out, irq_out, er;
  logic [7:0] pk[$], pg;
  logic [13:0] notes[$], nt, sn;
  logic [31:0] w[12];
  int n_mismatch = 0;
  int checked = 0;

  always #4 ref_clk_in = ~ref_clk_in;

  ncp_decoder ncp_decoder_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .apb_in(apb_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .pkt_in(pkt), .cal_evt_in(cal_evt_in),
    .cal_cmd_out(cal_cmd_out), .cal_rpt_out(cal_rpt_out),
    .odo_auto_out(odo_auto_out), .odo_len_out(odo_len_out),
    .align_out(align_out), .prim_off_out(prim_off_out),
    .heave_off_out(heave_off_out), .save_out(save_out), .irq_out(irq_out));
  ncp_host ncp_host_inst (.clk_in(ref_clk_in), .pkt_out(pkt));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic put32(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      pk.push_back(v[8*i +: 8]);
  endtask

  // note layout: cmd pulses, align, save valid, save id
  task automatic go(input logic [13:0] n);
    if (n !== 14'h0000)
      notes.push_back(n);
    ncp_host_inst.send(pk);
    repeat (3) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    apb_in <= '{1'b1, 1'b0, wr, a, d};
    @(posedge ref_clk_in);
    apb_in.penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1)
    begin
      n_mismatch++;
      end_of_test();
    end
    rd = prdata_out;
    er = pslverr_out;
    apb_in <= '0;
    #1;
  endtask

  task automatic calp(input logic [7:0] act, input logic [3:0] cmd,
                      input logic [7:0] ex);
    pk = {ncp_pkg::ID_CAL_CMD, act};
    go({cmd, 10'h000});
    `CHK("cal code", ex, cal_rpt_out.code)
  endtask

  task automatic cale(input logic [2:0] dfc, input logic [7:0] fc,
                      input logic [7:0] ex);
    pg = 8'(rnd());
    @(posedge ref_clk_in);
    cal_evt_in <= '{dfc[2], dfc[1], dfc[0], fc, pg, ~pg};
    @(posedge ref_clk_in);
    cal_evt_in <= '{1'b0, 1'b0, 1'b0, fc, pg, ~pg};
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK("cal code", ex, cal_rpt_out.code)
    `CHK("progress", {pg, ~pg}, cal_rpt_out[15:0])
  endtask

  // pulses seen at an edge are matched with the oldest note
  always @(posedge ref_clk_in)
  begin
    if (!rst_in && {cal_cmd_out, align_out, save_out.valid} !== 6'h00)
    begin
      nt = notes.size() > 0 ? notes.pop_front() : 14'h0000;
      sn = {cal_cmd_out, align_out, save_out.valid,
            save_out.valid ? save_out.id : 8'h00};
      `CHK("event", nt, sn)
    end
  end

  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
    `CHK("prim", 96'h0, prim_off_out)
    `CHK("heave", 288'h0, heave_off_out)
    `CHK("rpt id", ncp_pkg::ID_CAL_STAT, cal_rpt_out.id)
    `CHK("code", ncp_pkg::ST_NONE, cal_rpt_out.code)
    apb(1'b1, ncp_pkg::A_IRQ_MASK, 32'h0000000F);
    calp(ncp_pkg::ACT_2D, 4'h4, ncp_pkg::ST_RUN2D);
    cale(3'b100, 8'h00, ncp_pkg::ST_DONE2D);
    calp(ncp_pkg::ACT_3D, 4'h2, ncp_pkg::ST_RUN3D);
    cale(3'b100, 8'h00, ncp_pkg::ST_DONE3D);
    for (int k = 7; k <= 12; k++)
    begin
      calp(ncp_pkg::ACT_3D, 4'h2, ncp_pkg::ST_RUN3D);
      cale(3'b010, 8'(k), 8'(k));
    end
    cale(3'b001, 8'h00, ncp_pkg::ST_CUSTOM);
    calp(ncp_pkg::ACT_DEFAULT, 4'h1, ncp_pkg::ST_NONE);
    calp(ncp_pkg::ACT_2D, 4'h4, ncp_pkg::ST_RUN2D);
    calp(ncp_pkg::ACT_CANCEL, 4'h8, ncp_pkg::ST_NONE);
    calp(8'h05, 4'h0, ncp_pkg::ST_NONE);
    apb(1'b0, ncp_pkg::A_CAL, 32'h0);
    `CHK("cal reg", {8'h00, ~pg, pg, ncp_pkg::ST_NONE}, rd)
    $display("end of test calibration");
    w[0] = rnd();
    pk = {ncp_pkg::ID_ODO, 8'h01, 8'h01, 8'h00, 8'h00};
    put32(w[0]);
    go({6'h01, ncp_pkg::ID_ODO});
    `CHK("odo auto", 1'b1, odo_auto_out)
    `CHK("odo len", w[0], odo_len_out)
    pk = {ncp_pkg::ID_ODO, 8'h00, 8'h00, 8'h00, 8'h00};
    put32(~w[0]);
    void'(pk.pop_back());
    go(14'h0000);
    `CHK("odo len", w[0], odo_len_out)
    `CHK("odo auto", 1'b1, odo_auto_out)
    apb(1'b0, ncp_pkg::A_ODO_LEN, 32'h0);
    `CHK("odo reg", w[0], rd)
    $display("end of test odometer");
    apb(1'b1, ncp_pkg::A_IRQ_STAT, 32'h0000000F);
    `CHK("irq", 1'b0, irq_out)
    pk = {ncp_pkg::ID_ALIGN, 8'h00};
    put32(ncp_pkg::ALIGN_KEY ^ (rnd() | 32'h1));
    go(14'h0000);
    pk = {ncp_pkg::ID_ALIGN, 8'h01};
    go(14'h0000);
    apb(1'b0, ncp_pkg::A_IRQ_STAT, 32'h0);
    `CHK("stat", 32'h00000002, rd)
    pk = {ncp_pkg::ID_ALIGN, 8'h00};
    put32(ncp_pkg::ALIGN_KEY);
    go(14'h0200);
    `CHK("irq", 1'b1, irq_out)
    apb(1'b0, ncp_pkg::A_IRQ_STAT, 32'h0);
    `CHK("stat", 32'h00000007, rd)
    apb(1'b1, ncp_pkg::A_IRQ_MASK, 32'h0);
    `CHK("irq", 1'b0, irq_out)
    $display("end of test alignment");
    pk = {ncp_pkg::ID_OFFS, 8'h01};
    for (int i = 0; i < 12; i++)
    begin
      w[i] = rnd();
      put32(w[i]);
    end
    go({6'h01, ncp_pkg::ID_OFFS});
    `CHK("prim", {w[0], w[1], w[2]}, prim_off_out)
    `CHK("heave", {w[9], w[10], w[11], w[6], w[7], w[8], w[3], w[4], w[5]},
      heave_off_out)
    pk = {ncp_pkg::ID_OFFS, 8'h00};
    for (int i = 0; i < 13; i++)
      put32(~w[i % 12]);
    go(14'h0000);
    `CHK("prim", {w[0], w[1], w[2]}, prim_off_out)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, er)
    `CHK("rdata", 32'h0, rd)
    `CHK("notes left", 0, notes.size())
    $display("end of test offsets");
    end_of_test();
  end
endmodule
